// ===== rtl/relay_driver_consts.svh
// Constants of the eight-channel relay driver serial control block.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef RELAY_DRIVER_CONSTS_SVH
`define RELAY_DRIVER_CONSTS_SVH

// Number of load channels and width of the command and status words.
`define CHANNEL_COUNT 8
// Bit position of the command word that steers the highest channel.
`define COMMAND_MSB 7
// Bit position of the command word that steers the lowest channel.
`define COMMAND_LSB 0
// Reset value of the channel enable word: every channel off.
`define CHANNEL_ENABLE_RESET 8'h00
// Reset value of the latched fault bits.
`define CHANNEL_FAULT_RESET 8'h00
// System clock rate in MHz.
`define SYS_CLK_MHZ 250
// Least time a fault must persist before it is latched, in ns.
`define FAULT_FILTER_TIME_NS 140000
// Cycles of the fault filter, rounded up to whole cycles.
`define FAULT_FILTER_CYCLES \
   ((`FAULT_FILTER_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
// Depth of every pin synchroniser.
`define SYNC_STAGES 2

`endif

// ===== rtl/relay_driver_pkg.sv
// Types shared by the relay driver serial control block.
// Assumes the constants header sits beside it on the include path.
`include "relay_driver_consts.svh"

package relay_driver_pkg;

   // The three wires of the serial link, as sampled from the pins.
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } serial_pins_s;

   // Per-channel fault sense lines from the analog output stages.
   typedef struct packed {
      logic [`CHANNEL_COUNT-1:0] overcurrent;
      logic [`CHANNEL_COUNT-1:0] open_load;
   } fault_sense_s;

   typedef logic [`CHANNEL_COUNT-1:0] channel_word_t;

endpackage

// ===== rtl/relay_driver_serial_control.sv
// Serial control and diagnostics logic of an eight-channel low-side driver.
// Assumes every pin input is asynchronous to i_clk and that the serial
// clock runs well below a quarter of i_clk, as the link limit ensures.
//
// Behaviour
// - Command bit 7 steers channel 8, bit 0 steers channel 1, others alike.
// - While select is low, each serial clock rise shifts input into register.
// - Select rising copies the shift register into the channel enable word.
// - Select falling loads per-channel status into the shift register.
// - Serial output advances one bit on each serial clock fall in a frame.
// - Enable word keeps its state while select is low, changes only on its rise.
// - With select high, serial pins are ignored; output shows shift MSB.
// - Any bit count per frame leaves only the latest eight bits held.
// - A fault lasting past the filter time latches its channel status bit.
// - Select rising clears the latched fault data.
// - Status bit equals command bit, or its inverse if the channel faulted.
// - Fault indicator pulls low while any channel fault is present.
// - An active channel sinks current, otherwise high impedance: an enable.
// - With latch-off disabled, an overloaded channel keeps running.
// - Thermal shutdown turns every channel off, overriding the enable word.
// - Three-wire serial framing, serial clock up to 10 MHz.
// - One reset input turns all channels off together.
// - Reset pin low clears shift, enable and status registers, channels off.
// - Latch-off enabled: an overload turns the channel off until next word.
// - Latch-off disabled: overload stays current limited until it clears.
// - A channel on with a low status bit reports a short to supply.
`timescale 1ns/100ps
`default_nettype none
`include "relay_driver_consts.svh"

module relay_driver_serial_control
   import relay_driver_pkg::*;
#(
   parameter int FAULT_FILTER_CYC = `FAULT_FILTER_CYCLES,
   parameter int CH = `CHANNEL_COUNT
) (
   // System clock and reset.
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Device reset pin, active low.
   input wire logic i_reset_n,
   // Serial link pins.
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_din,
   output logic o_dout,
   // Protection control and sense lines from the analog stages.
   input wire logic i_short_latchoff_disable,
   input wire logic i_thermal_shutdown,
   input wire logic [CH-1:0] i_overcurrent,
   input wire logic [CH-1:0] i_open_load,
   // Open-drain fault indicator: level, and enable while pulling low.
   output logic o_fault_n,
   output logic o_fault_oe,
   // Per-channel sink enables toward power_ground.
   output logic [CH-1:0] o_chan_sink_en
);

   localparam int CNT_W = $clog2(FAULT_FILTER_CYC + 1);
   localparam logic [CNT_W-1:0] FILTER_LAST =
      CNT_W'(FAULT_FILTER_CYC - 1);

   // Two-flop synchronisers for every pin input.
   localparam int SYNC_W = 3 + 3 + 2 * CH;
   // Levels held during system reset: select high and the reset pin
   // released, so that leaving reset shows no false select edge.
   localparam logic [SYNC_W-1:0] SYNC_IDLE =
      {1'b1, 1'b0, 1'b0, 1'b1, {(SYNC_W-4){1'b0}}};

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_sync;

   assign pins_raw = {i_cs_n, i_sclk, i_din, i_reset_n,
                      i_short_latchoff_disable, i_thermal_shutdown,
                      i_overcurrent, i_open_load};

   genvar s;
   generate
      for (s = 0; s < SYNC_W; s = s + 1) begin : g_sync
         logic sync1_q;
         logic sync2_q;

         // Nothing but the second stage reads the first.
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               sync1_q <= SYNC_IDLE[s];
               sync2_q <= SYNC_IDLE[s];
            end else begin
               sync1_q <= pins_raw[s];
               sync2_q <= sync1_q;
            end
         end

         assign pins_sync[s] = sync2_q;
      end
   endgenerate

   serial_pins_s link;
   fault_sense_s sense;
   logic reset_pin_n;
   logic latchoff_dis;
   logic thermal;

   assign link.cs_n = pins_sync[SYNC_W-1];
   assign link.sclk = pins_sync[SYNC_W-2];
   assign link.din = pins_sync[SYNC_W-3];
   assign reset_pin_n = pins_sync[SYNC_W-4];
   assign latchoff_dis = pins_sync[SYNC_W-5];
   assign thermal = pins_sync[SYNC_W-6];
   assign sense.overcurrent = pins_sync[2*CH-1:CH];
   assign sense.open_load = pins_sync[CH-1:0];

   // Internal reset: system reset or the device reset pin held low.
   logic rst;

   assign rst = i_sys_rst | ~reset_pin_n;

   // Edge detection on the synchronised link wires.
   serial_pins_s link_prev_q;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         link_prev_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      end else begin
         link_prev_q <= link;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic in_frame;

   assign cs_fall = link_prev_q.cs_n & ~link.cs_n;
   assign cs_rise = ~link_prev_q.cs_n & link.cs_n;
   assign in_frame = ~link.cs_n & ~link_prev_q.cs_n;
   assign sclk_rise = in_frame & ~link_prev_q.sclk & link.sclk;
   assign sclk_fall = in_frame & link_prev_q.sclk & ~link.sclk;

   // Registers of the block and the status word derived from them.
   channel_word_t shift_q;
   channel_word_t enable_word_q;
   channel_word_t fault_latch_q;
   channel_word_t latched_off_q;
   channel_word_t status_word;

   // Status bit follows the command bit, inverted for a faulted channel.
   function automatic channel_word_t status_of(input channel_word_t cmd,
                                               input channel_word_t flt);
      status_of = cmd ^ flt;
   endfunction

   assign status_word = status_of(enable_word_q, fault_latch_q);

   // Shift register: load status at frame start, shift on serial rise.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         shift_q <= `CHANNEL_ENABLE_RESET;
      end else if (cs_fall) begin
         shift_q <= status_word;
      end else if (sclk_rise) begin
         // Older bits fall off the top, so the latest eight remain.
         shift_q <= {shift_q[`COMMAND_MSB-1:`COMMAND_LSB], link.din};
      end
   end

   // Serial output: shift MSB when idle, advanced on each serial fall.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_dout <= 1'b0;
      end else if (cs_fall) begin
         o_dout <= status_word[`COMMAND_MSB];
      end else if (sclk_fall) begin
         o_dout <= shift_q[`COMMAND_MSB];
      end else if (link.cs_n) begin
         o_dout <= shift_q[`COMMAND_MSB];
      end
   end

   // Channel enable word: taken from the shift register on select rise.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         enable_word_q <= `CHANNEL_ENABLE_RESET;
      end else if (cs_rise) begin
         // Bit n steers channel n+1; one means on.
         enable_word_q <= shift_q;
      end
   end

   // Per-channel fault filter, latch and latch-off.
   channel_word_t filter_done;
   channel_word_t raw_fault;

   genvar g;
   generate
      for (g = 0; g < CH; g = g + 1) begin : g_chan
         logic [CNT_W-1:0] filt_cnt_q;
         logic flt_q;
         logic off_q;

         // An on channel can overload; an off channel can read open.
         assign raw_fault[g] = o_chan_sink_en[g] ? sense.overcurrent[g]
                                                  : sense.open_load[g];
         assign filter_done[g] = raw_fault[g] & (filt_cnt_q == FILTER_LAST);

         // Counts while the fault stands; any break restarts it.
         always_ff @(posedge i_clk) begin
            if (rst) begin
               filt_cnt_q <= '0;
            end else if (!raw_fault[g]) begin
               filt_cnt_q <= '0;
            end else if (filt_cnt_q != FILTER_LAST) begin
               filt_cnt_q <= filt_cnt_q + CNT_W'(1);
            end
         end

         // Latched fault bit: a new fault wins over the clear on select.
         always_ff @(posedge i_clk) begin
            if (rst) begin
               flt_q <= 1'b0;
            end else if (filter_done[g]) begin
               flt_q <= 1'b1;
            end else if (cs_rise) begin
               flt_q <= 1'b0;
            end
         end

         assign fault_latch_q[g] = flt_q;

         // Latch-off of an overloaded channel until the next word.
         // An open load is only reported, as that channel is off anyway.
         always_ff @(posedge i_clk) begin
            if (rst) begin
               off_q <= 1'b0;
            end else if (filter_done[g] && o_chan_sink_en[g] &&
                         !latchoff_dis) begin
               off_q <= 1'b1;
            end else if (cs_rise) begin
               off_q <= 1'b0;
            end
         end

         assign latched_off_q[g] = off_q;
      end
   endgenerate

   // Sink enables: word, less latched-off channels, less thermal shutdown.
   // With latch-off disabled the channel stays on; the stage limits current.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_chan_sink_en <= `CHANNEL_ENABLE_RESET;
      end else if (thermal) begin
         o_chan_sink_en <= `CHANNEL_ENABLE_RESET;
      end else begin
         o_chan_sink_en <= enable_word_q & ~latched_off_q;
      end
   end

   // Fault indicator: pulls low on any latched fault or thermal shutdown.
   logic fault_any;

   assign fault_any = |fault_latch_q | thermal;

   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_fault_n <= 1'b1;
      end else begin
         o_fault_n <= ~fault_any;
      end
   end

   // The open-drain pin is driven only while it pulls low.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_fault_oe <= 1'b0;
      end else begin
         o_fault_oe <= fault_any;
      end
   end

endmodule
`default_nettype wire

// ===== tb/relay_driver_checker.sv
// Port checker of the relay driver serial control block.
// Assumes a bind from the bench top file onto the design top.
`timescale 1ns/100ps
`default_nettype none
module relay_driver_checker
   import relay_driver_pkg::*;
#(parameter int FAULT_FILTER_CYC = 8) (
   // Clock, resets and inputs.
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reset_n,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_short_latchoff_disable,
   input wire logic i_thermal_shutdown,
   input wire channel_word_t i_overcurrent,
   input wire channel_word_t i_open_load,
   // Outputs.
   input wire logic o_dout,
   input wire logic o_fault_n,
   input wire logic o_fault_oe,
   input wire channel_word_t o_chan_sink_en
);
   logic [3:0] lo_q, rise_q, evt_q, qa_q, qb_q;
   logic [7:0] raw_q;
   logic cs_q, sc_q, raw;
   function automatic logic [3:0] sat(input logic [3:0] x, input logic c);
      return c ? 4'h0 : x + {3'h0, x != 4'hf};
   endfunction
   assign raw = i_reset_n && rise_q > 4'h6 && ((i_open_load &
      ~o_chan_sink_en) | (i_overcurrent & o_chan_sink_en)) != 8'h00;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         {lo_q, rise_q, evt_q, qa_q, qb_q, raw_q} <= '0;
      end else begin
         lo_q <= sat(lo_q, i_cs_n);
         rise_q <= sat(rise_q, i_cs_n && !cs_q);
         evt_q <= sat(evt_q, (i_cs_n != cs_q) || (sc_q && !i_sclk));
         qa_q <= sat(qa_q, i_overcurrent != 8'h00 || !i_reset_n ||
            i_thermal_shutdown);
         qb_q <= sat(qb_q, i_thermal_shutdown || !i_reset_n);
         raw_q <= raw ? raw_q + {7'h00, raw_q != 8'hff} : 8'h00;
      end
      cs_q <= i_cs_n;
      sc_q <= i_sclk;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   hold_frame_a: assert property (lo_q > 4'h5 && qa_q > 4'h5
      |=> $stable(o_chan_sink_en)) else $error("sink moved in frame");
   flag_pin_a: assert property (o_fault_oe == !o_fault_n)
      else $error("flag enable disagrees");
   thermal_off_a: assert property (i_thermal_shutdown [*4]
      |-> o_chan_sink_en == 8'h00 && !o_fault_n) else $error("thermal");
   reset_pin_a: assert property (!i_reset_n [*4] |->
      o_chan_sink_en == 8'h00 && o_fault_n && !o_dout) else $error("reset");
   apply_rise_a: assert property (qb_q > 4'h7 && (o_chan_sink_en &
      ~$past(o_chan_sink_en)) != 8'h00 |-> rise_q inside {[4'h2:4'h7]})
      else $error("sink rose without select rise");
   dout_edge_a: assert property ($changed(o_dout) && qb_q > 4'h7
      |-> evt_q inside {[4'h1:4'h6]}) else $error("dout moved off edge");
   no_latchoff_a: assert property (i_short_latchoff_disable &&
      $past(i_short_latchoff_disable, 4) && qb_q > 4'h7 && rise_q > 4'h8
      |=> ($past(o_chan_sink_en) & ~o_chan_sink_en) == 8'h00)
      else $error("channel dropped with latch-off disabled");
   flag_clear_a: assert property ($rose(o_fault_n) && qb_q > 4'h7
      |-> rise_q inside {[4'h2:4'h7]}) else $error("flag cleared early");
   fault_latch_a: assert property (int'(raw_q) > FAULT_FILTER_CYC + 5
      |-> !o_fault_n) else $error("fault not flagged");
   cover property (lo_q == 4'hf);
   cover property ($fell(o_fault_n));
   cover property ($rose(o_chan_sink_en[0]));
endmodule
`default_nettype wire

// ===== tb/host_link_model.sv
// Host serial controller model driving the three-wire link.
// Assumes the bench calls xfer from its main sequence.
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   // Link pins toward the device.
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_din,
   input wire logic i_dout
);
   initial {o_cs_n, o_sclk, o_din} = 3'b100;
   // Sends n bits of w, MSB first, with a 32 ns serial clock; the clock
   // stands low outside frames and din flips once released.
   task automatic xfer(input logic [15:0] w, input int n,
      output logic [7:0] rd);
      #1 o_cs_n = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         o_din = w[i];
         #16 o_sclk = 1'b1;
         #16 rd = {rd[6:0], i_dout};
         o_sclk = 1'b0;
      end
      #40 o_cs_n = 1'b1;
      o_din = ~o_din;
      #40;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_relay_driver_serial_control.sv
// Self-checking bench of the relay driver serial control block.
// Assumes package, design, checker and host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_relay_driver_serial_control
   import relay_driver_pkg::*;
();
   logic clk, rst, rst_n, cs_n, sclk, din, dout, sld, thr, flt_n, flt_oe;
   channel_word_t oc, ol, sink, rd, prev, old;
   logic [31:0] lfsr;
   int mismatches, cmp_count;
   host_link_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
      .i_dout(dout));
   relay_driver_serial_control #(.FAULT_FILTER_CYC(8)) uut (.i_clk(clk),
      .i_sys_rst(rst), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_din(din), .o_dout(dout), .i_short_latchoff_disable(sld),
      .i_thermal_shutdown(thr), .i_overcurrent(oc), .i_open_load(ol),
      .o_fault_n(flt_n), .o_fault_oe(flt_oe), .o_chan_sink_en(sink));
   function automatic channel_word_t keep8(input channel_word_t w,
      input logic [15:0] b, input int n);
      logic [23:0] t;
      t = ({16'h0000, w} << n) | {8'h00, b};
      return t[7:0];
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check_flag(input logic got, input logic e,
      input string msg);
      cmp_count++;
      if (got !== e) begin
         mismatches++;
         $display("mismatch at %0t: %s %b/%b", $time, msg, got, e);
      end
   endtask
   task automatic check(input channel_word_t got, input channel_word_t e,
      input string msg);
      cmp_count++;
      if (got !== e) begin
         mismatches++;
         $display("mismatch at %0t: %s %h/%h", $time, msg, got, e);
      end
   endtask
   task automatic frame(input logic [15:0] b, input int n);
      old = prev;
      @(posedge clk);
      host.xfer(b, n, rd);
      prev = keep8(prev, b, n);
      check(sink, prev, "sink");
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wait_chk(input int c, input channel_word_t s,
      input logic f);
      repeat (c) @(posedge clk);
      check(sink, s, "sink");
      check_flag(flt_n, f, "flag");
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #200000 mismatches++;
      complete_run();
   end
   initial begin
      {rst, rst_n, sld, thr, oc, ol} = 20'hc0000;
      lfsr = 32'h00013ec9;
      prev = 8'h00;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         frame(i == 0 ? 16'h00ff : {8'h00, lfsr[7:0] & {8{i > 1}}}, 8);
         check(rd, old, "status");
      end
      frame(16'h0005, 4);
      frame({4'h0, lfsr[19:8]}, 12);
      $display("test serial words done");
      frame(16'h0081, 8);
      oc <= 8'h01;
      wait_chk(20, 8'h80, 1'b0);
      oc <= 8'h00;
      frame(16'h0081, 8);
      check(rd, 8'h80, "short");
      check_flag(flt_n, 1'b1, "clear");
      ol <= 8'h02;
      repeat (20) @(posedge clk);
      ol <= 8'h00;
      frame(16'h0081, 8);
      check(rd, 8'h83, "open");
      {sld, oc} <= 9'h180;
      wait_chk(30, 8'h81, 1'b0);
      {sld, oc, thr} <= 10'h001;
      wait_chk(5, 8'h00, 1'b0);
      thr <= 1'b0;
      repeat (5) @(posedge clk);
      check(sink, 8'h81, "thermal end");
      rst_n <= 1'b0;
      wait_chk(6, 8'h00, 1'b1);
      rst_n <= 1'b1;
      prev = 8'h00;
      repeat (5) @(posedge clk);
      frame(16'h003c, 8);
      check(rd, 8'h00, "cleared");
      $display("test faults done");
      complete_run();
   end
endmodule
bind relay_driver_serial_control relay_driver_checker
   #(.FAULT_FILTER_CYC(FAULT_FILTER_CYC)) chk (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
   .i_sclk(i_sclk), .i_short_latchoff_disable(i_short_latchoff_disable),
   .i_thermal_shutdown(i_thermal_shutdown), .i_overcurrent(i_overcurrent),
   .i_open_load(i_open_load), .o_dout(o_dout), .o_fault_n(o_fault_n),
   .o_fault_oe(o_fault_oe), .o_chan_sink_en(o_chan_sink_en));
`default_nettype wire
